//--- rtl/stirq_consts.svh
// register offsets, field positions and reset values of the status bank
// assumes inclusion by bare name from the design files
`ifndef STIRQ_CONSTS_SVH
`define STIRQ_CONSTS_SVH
`define STIRQ_OFF_ID_HIGH 8'h30
`define STIRQ_OFF_ID_LOW_REV 8'h31
`define STIRQ_OFF_STRAP 8'h40
`define STIRQ_OFF_PIN_LEVEL 8'h41
`define STIRQ_OFF_TOP 8'h42
`define STIRQ_OFF_CHIPWIDE 8'h43
`define STIRQ_OFF_OUT_CLK 8'h45
`define STIRQ_OFF_PLL_SUM 8'h46
`define STIRQ_OFF_PLL_STAT 8'h48
`define STIRQ_OFF_PA_STAT 8'h4d
`define STIRQ_OFF_MEAS_STAT 8'h4b
`define STIRQ_OFF_OC1_STAT 8'h53
// top summary bit positions
`define STIRQ_TOP_CHIPWIDE 6
`define STIRQ_TOP_OUTCLK 5
`define STIRQ_TOP_PLL 2
`define STIRQ_TOP_EN 1
`define STIRQ_TOP_IRQ 0
// pll status positions
`define STIRQ_PLL_LK2_EN 6
`define STIRQ_PLL_LK2_CHG 5
`define STIRQ_PLL_LK2 4
`define STIRQ_PLL_LK_EN 2
`define STIRQ_PLL_LK_CHG 1
`define STIRQ_PLL_LK 0
// phase adjust, measure and chip-wide summary positions
`define STIRQ_PA_EN 3
`define STIRQ_PA_DONE 2
`define STIRQ_MS_EN 5
`define STIRQ_MS_RDY 4
`define STIRQ_CW_BOOT 7
`define STIRQ_CW_PA 1
`define STIRQ_CW_MS 0
`define STIRQ_ZERO8 8'h00
`endif

//--- rtl/stirq_pkg.sv
// types shared by the status bank
// assumes the constants header is also included where needed
package stirq_pkg;
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [7:0] addr; // register offset
    logic [7:0] wdata; // write data
  } stirq_req_s;
  typedef struct packed {
    logic test; // test strap
    logic [1:0] port_sel; // host port straps
    logic [1:0] boot_image_strap; // boot image straps
  } stirq_strap_s;
  typedef enum logic [1:0] {
    STIRQ_IN_RESET = 2'b00,
    STIRQ_CAPTURE = 2'b01,
    STIRQ_RUN = 2'b10
  } stirq_state_e;
endpackage : stirq_pkg

//--- rtl/stirq_sync.sv
// two-stage synchroniser for a vector of levels
// assumes asynchronous levels on d, one clock
`timescale 1ns/1ps
module stirq_sync #(
  parameter int W = 5
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [W-1:0] d, // async levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  // next values: first stage only feeds second
  always_comb begin
    nxt_meta = srst ? '0 : d;
    nxt_q = srst ? '0 : meta_ff;
  end

  // registers
  always_ff @(posedge clk) begin
    meta_ff <= nxt_meta;
    q <= nxt_q;
  end
endmodule : stirq_sync

//--- rtl/stirq_status_bank.sv
// status bank with hierarchical interrupt summary tree
// assumes inputs synchronous except pins and osc flag; one clock
// What this block does
// - reads fixed upper eight identifier bits at first identification address
// - lower four identifier bits in bits 7-4 of second id register
// - revision field in bits 3-0 of second id register
// - test strap captured into strap bit 7 when reset pin rises
// - strap bit 6 shows oscillator or crystal failure
// - host port straps captured into bits 3-2 on reset pin rise
// - boot image straps captured into bits 1-0 on reset pin rise
// - pin status bits 3-0 show live pin levels, no inversion
// - top bit 6 is OR of chip-wide summary bits 1-0; boot bit 7 does not feed it
// - top bit 5 is OR of output-clock summary bits
// - top bit 2 is OR of pll summary bits
// - top bit 1 is writable global enable gating the indication
// - top bit 0 is OR of three categories gated by enable
// - top indication only leaves through a pin configured to follow
// - boot finished bit clears on reset, sets when boot completes
// - phase adjust summary is OR of enabled latched flags
// - phase measure summary is OR of enabled latched flags
// - output summaries bits 2-0 per output 3,2,1 enabled flags
// - pll summary is OR of enabled latched pll flags
// - pll lock change flags set on any edge, clear on write one
// - each enable lets its flag feed the summary tree
// - measure ready flag sets when a new result arrives
`timescale 1ns/1ps
`include "stirq_consts.svh"
module stirq_status_bank #(
  parameter logic [7:0] PART_CODE_HIGH = 8'h5a, // arbitrary id value
  parameter logic [3:0] PART_CODE_LOW = 4'ha, // arbitrary id value
  parameter logic [3:0] SILICON_VERSION = 4'h0 // arbitrary revision
) (
  input wire logic clk, // system clock 10 MHz
  input wire logic srst, // synchronous reset, high
  input wire logic reset_pin_n, // device reset pin, low active
  input wire stirq_pkg::stirq_req_s req, // host register access
  output logic [7:0] rdata, // read data, registered
  input wire stirq_pkg::stirq_strap_s straps, // strap pin levels
  input wire logic osc_failure, // oscillator fail, async
  input wire logic [3:0] gp_pin, // general pin levels, async
  input wire logic boot_finished, // boot controller done level
  input wire logic pll_lock_live, // live lock status 1
  input wire logic pll_lock2_live, // live lock status 2
  input wire logic pa_done_evt, // phase adjust finished pulse
  input wire logic measure_done_evt, // new measurement pulse
  input wire logic [2:0] oc_evt_sum, // per-output enabled flags
  output logic top_irq // top indication for pin routing
);
  logic [4:0] sync_q;
  stirq_pkg::stirq_strap_s strap_ff, nxt_strap;
  stirq_pkg::stirq_state_e st_ff, nxt_st;
  logic boot_ff, nxt_boot;
  logic chipwide_summary_en_ff, nxt_chipwide_summary_en;
  logic lk_prev_ff, lk2_prev_ff, nxt_lk_prev, nxt_lk2_prev;
  logic lk_chg_ff, lk2_chg_ff, nxt_lk_chg, nxt_lk2_chg;
  logic lk_en_ff, lk2_en_ff, nxt_lk_en, nxt_lk2_en;
  logic pa_done_ff, pa_en_ff, nxt_pa_done, nxt_pa_en;
  logic ms_rdy_ff, ms_en_ff, nxt_ms_rdy, nxt_ms_en;
  logic [7:0] nxt_rdata;
  logic nxt_irq;
  logic wr_pll, wr_pa, wr_ms, wr_top;
  logic pa_sum, ms_sum, pll_sum, cw_any, oc_any, pll_any;
  logic [7:0] cw_reg, oc_reg, pll_reg, top_reg, strap_reg;

  // synchronise pins and oscillator fail
  stirq_sync #(.W(5)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({osc_failure, gp_pin}),
    .q(sync_q)
  );

  assign wr_pll = req.wr && req.addr == `STIRQ_OFF_PLL_STAT;
  assign wr_pa = req.wr && req.addr == `STIRQ_OFF_PA_STAT;
  assign wr_ms = req.wr && req.addr == `STIRQ_OFF_MEAS_STAT;
  assign wr_top = req.wr && req.addr == `STIRQ_OFF_TOP;

  // summary tree, combinational from flags and enables
  always_comb begin
    pa_sum = pa_done_ff & pa_en_ff;
    ms_sum = ms_rdy_ff & ms_en_ff;
    pll_sum = (lk_chg_ff & lk_en_ff) | (lk2_chg_ff & lk2_en_ff);
    cw_any = pa_sum | ms_sum;
    oc_any = |oc_evt_sum;
    pll_any = pll_sum;
    nxt_irq = chipwide_summary_en_ff & (cw_any | oc_any | pll_any);
    cw_reg = `STIRQ_ZERO8;
    cw_reg[`STIRQ_CW_BOOT] = boot_ff;
    cw_reg[`STIRQ_CW_PA] = pa_sum;
    cw_reg[`STIRQ_CW_MS] = ms_sum;
    oc_reg = {5'h00, oc_evt_sum};
    pll_reg = {7'h00, pll_sum};
    top_reg = `STIRQ_ZERO8;
    top_reg[`STIRQ_TOP_CHIPWIDE] = cw_any;
    top_reg[`STIRQ_TOP_OUTCLK] = oc_any;
    top_reg[`STIRQ_TOP_PLL] = pll_any;
    top_reg[`STIRQ_TOP_EN] = chipwide_summary_en_ff;
    top_reg[`STIRQ_TOP_IRQ] = nxt_irq;
    strap_reg = {strap_ff.test, sync_q[4], 2'h0,
                 strap_ff.port_sel, strap_ff.boot_image_strap};
  end

  // strap capture on reset pin release
  always_comb begin
    nxt_st = st_ff;
    nxt_strap = strap_ff;
    case (st_ff)
      stirq_pkg::STIRQ_IN_RESET: begin
        if (reset_pin_n) begin
          nxt_strap = straps;
          nxt_st = stirq_pkg::STIRQ_RUN;
        end
      end
      stirq_pkg::STIRQ_RUN: begin
        if (!reset_pin_n) begin
          nxt_st = stirq_pkg::STIRQ_IN_RESET;
        end
      end
      default: nxt_st = stirq_pkg::STIRQ_IN_RESET;
    endcase
    if (srst) begin
      nxt_st = stirq_pkg::STIRQ_IN_RESET;
      nxt_strap = '0;
    end
  end

  // latched flags: set wins over write-one clear
  always_comb begin
    nxt_lk_prev = pll_lock_live;
    nxt_lk2_prev = pll_lock2_live;
    nxt_lk_chg = (lk_chg_ff & ~(wr_pll & req.wdata[`STIRQ_PLL_LK_CHG]))
                 | (pll_lock_live ^ lk_prev_ff);
    nxt_lk2_chg = (lk2_chg_ff & ~(wr_pll & req.wdata[`STIRQ_PLL_LK2_CHG]))
                  | (pll_lock2_live ^ lk2_prev_ff);
    nxt_lk_en = wr_pll ? req.wdata[`STIRQ_PLL_LK_EN] : lk_en_ff;
    nxt_lk2_en = wr_pll ? req.wdata[`STIRQ_PLL_LK2_EN] : lk2_en_ff;
    nxt_pa_done = (pa_done_ff & ~(wr_pa & req.wdata[`STIRQ_PA_DONE]))
                  | pa_done_evt;
    nxt_pa_en = wr_pa ? req.wdata[`STIRQ_PA_EN] : pa_en_ff;
    nxt_ms_rdy = (ms_rdy_ff & ~(wr_ms & req.wdata[`STIRQ_MS_RDY]))
                 | measure_done_evt;
    nxt_ms_en = wr_ms ? req.wdata[`STIRQ_MS_EN] : ms_en_ff;
    nxt_chipwide_summary_en = wr_top ? req.wdata[`STIRQ_TOP_EN] : chipwide_summary_en_ff;
    nxt_boot = boot_finished & reset_pin_n;
    if (srst) begin
      nxt_lk_prev = 1'b0;
      nxt_lk2_prev = 1'b0;
      nxt_lk_chg = 1'b0;
      nxt_lk2_chg = 1'b0;
      nxt_lk_en = 1'b0;
      nxt_lk2_en = 1'b0;
      nxt_pa_done = 1'b0;
      nxt_pa_en = 1'b0;
      nxt_ms_rdy = 1'b0;
      nxt_ms_en = 1'b0;
      nxt_chipwide_summary_en = 1'b0;
      nxt_boot = 1'b0;
    end
  end

  // read mux, registered; unmapped reads zero
  always_comb begin
    nxt_rdata = rdata;
    if (req.rd) begin
      case (req.addr)
        `STIRQ_OFF_ID_HIGH: nxt_rdata = PART_CODE_HIGH;
        `STIRQ_OFF_ID_LOW_REV:
          nxt_rdata = {PART_CODE_LOW, SILICON_VERSION};
        `STIRQ_OFF_STRAP: nxt_rdata = strap_reg;
        `STIRQ_OFF_PIN_LEVEL: nxt_rdata = {4'h0, sync_q[3:0]};
        `STIRQ_OFF_TOP: nxt_rdata = top_reg;
        `STIRQ_OFF_CHIPWIDE: nxt_rdata = cw_reg;
        `STIRQ_OFF_OUT_CLK: nxt_rdata = oc_reg;
        `STIRQ_OFF_PLL_SUM: nxt_rdata = pll_reg;
        `STIRQ_OFF_PLL_STAT:
          nxt_rdata = {1'b0, lk2_en_ff, lk2_chg_ff, pll_lock2_live,
                       1'b0, lk_en_ff, lk_chg_ff, pll_lock_live};
        `STIRQ_OFF_PA_STAT: nxt_rdata = {4'h0, pa_en_ff, pa_done_ff, 2'h0};
        `STIRQ_OFF_MEAS_STAT: nxt_rdata = {2'h0, ms_en_ff, ms_rdy_ff, 4'h0};
        default: nxt_rdata = `STIRQ_ZERO8;
      endcase
    end
    if (srst) begin
      nxt_rdata = `STIRQ_ZERO8;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
    strap_ff <= nxt_strap;
    boot_ff <= nxt_boot;
    chipwide_summary_en_ff <= nxt_chipwide_summary_en;
    lk_prev_ff <= nxt_lk_prev;
    lk2_prev_ff <= nxt_lk2_prev;
    lk_chg_ff <= nxt_lk_chg;
    lk2_chg_ff <= nxt_lk2_chg;
    lk_en_ff <= nxt_lk_en;
    lk2_en_ff <= nxt_lk2_en;
    pa_done_ff <= nxt_pa_done;
    pa_en_ff <= nxt_pa_en;
    ms_rdy_ff <= nxt_ms_rdy;
    ms_en_ff <= nxt_ms_en;
    rdata <= nxt_rdata;
    top_irq <= srst ? 1'b0 : nxt_irq;
  end

  // checks
  a_irq_gated_off: assert property (@(posedge clk) disable iff (srst)
    !chipwide_summary_en_ff |=> !top_irq) else $error("irq while disabled");
  a_irq_follows_pll: assert property (@(posedge clk) disable iff (srst)
    chipwide_summary_en_ff && lk_chg_ff && lk_en_ff |=> top_irq)
    else $error("pll flag missed");
  a_lock_edge_sets: assert property (@(posedge clk) disable iff (srst)
    $changed(pll_lock_live) && !$past(srst) |=> lk_chg_ff)
    else $error("lock change not latched");
  a_lock2_edge_sets: assert property (@(posedge clk) disable iff (srst)
    $changed(pll_lock2_live) && !$past(srst) |=> lk2_chg_ff)
    else $error("lock2 change not latched");
  a_ready_sets: assert property (@(posedge clk) disable iff (srst)
    measure_done_evt |=> ms_rdy_ff) else $error("ready lost");
  a_id_read: assert property (@(posedge clk) disable iff (srst)
    req.rd && req.addr == `STIRQ_OFF_ID_HIGH |=> rdata == PART_CODE_HIGH)
    else $error("id read wrong");
  a_strap_hold: assert property (@(posedge clk) disable iff (srst)
    st_ff == stirq_pkg::STIRQ_RUN && reset_pin_n |=> $stable(strap_ff))
    else $error("strap changed while running");
  a_pin_two_stage: assert property (@(posedge clk) disable iff (srst)
    ##2 sync_q[3:0] == $past(gp_pin, 2)) else $error("pin sync");
endmodule : stirq_status_bank

//--- sim/stirq_host_model.sv
// host side model issuing register reads and writes to the status bank
// assumes strobes taken at posedge, read data one cycle after the read
`timescale 1ns/1ps
module stirq_host_model (
  input wire logic clk, // system clock
  output stirq_pkg::stirq_req_s req, // register access
  input wire logic [7:0] rdata // registered read data
);
  // bus idle from time zero
  initial begin
    req = '0;
  end
  // one write strobe held across a single edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #10;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) #10;
    req = '0;
  endtask : wr
  // one read strobe, data taken after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #10;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) #10;
    d = rdata;
    req = '0;
  endtask : rd
  // lock is trusted only when both live bits are set
  function automatic logic both_locked(input logic [7:0] s);
    return s[0] & s[4];
  endfunction : both_locked
endmodule : stirq_host_model

//--- sim/testbench.sv
// self-checking bench for the status bank and its summary tree
// assumes the host model drives the register strobes
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] ID_HI = 8'h3c; // arbitrary id value
  localparam logic [3:0] ID_LO = 4'h6; // arbitrary id value
  localparam logic [3:0] VER = 4'h2; // arbitrary revision
  logic clk, srst, reset_pin_n, osc_failure, boot_finished, top_irq;
  logic pll_lock_live, pll_lock2_live, pa_done_evt, measure_done_evt;
  logic [3:0] gp_pin;
  logic [2:0] oc_evt_sum;
  logic [7:0] rdata, v;
  stirq_pkg::stirq_req_s req;
  stirq_pkg::stirq_strap_s straps;
  int mismatches, n_checks, cycles;

  stirq_status_bank #(.PART_CODE_HIGH(ID_HI), .PART_CODE_LOW(ID_LO),
    .SILICON_VERSION(VER)) stirq_status_bank_inst (
    .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .req(req),
    .rdata(rdata), .straps(straps), .osc_failure(osc_failure),
    .gp_pin(gp_pin), .boot_finished(boot_finished),
    .pll_lock_live(pll_lock_live), .pll_lock2_live(pll_lock2_live),
    .pa_done_evt(pa_done_evt), .measure_done_evt(measure_done_evt),
    .oc_evt_sum(oc_evt_sum), .top_irq(top_irq));

  stirq_host_model host_inst (.clk(clk), .req(req), .rdata(rdata));

  // free running clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : step

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_inst.rd(a, v);
    check(v, exp);
  endtask : rd_chk

  task automatic give_verdict;
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    cycles = 0;
    srst = 1'b1;
    reset_pin_n = 1'b0;
    straps = '{test: 1'b1, port_sel: 2'b10, boot_image_strap: 2'b01};
    osc_failure = 1'b0;
    gp_pin = 4'h0;
    boot_finished = 1'b0;
    pll_lock_live = 1'b0;
    pll_lock2_live = 1'b0;
    pa_done_evt = 1'b0;
    measure_done_evt = 1'b0;
    oc_evt_sum = 3'h0;
    step(3);
    srst = 1'b0;
    reset_pin_n = 1'b1;
    step(2);
    straps = '0; // later pin changes must not reach the bank
    osc_failure = 1'b1;
    gp_pin = 4'ha;
    step(3);
    rd_chk(8'h30, ID_HI);
    host_inst.wr(8'h30, 8'hff);
    rd_chk(8'h30, ID_HI);
    rd_chk(8'h31, {ID_LO, VER});
    rd_chk(8'h40, 8'hc9);
    rd_chk(8'h41, 8'h0a);
    rd_chk(8'h44, 8'h00); // unmapped place reads zero
    rd_chk(8'h43, 8'h00);
    // lock flags, enables and the global gate
    pll_lock_live = 1'b1;
    pll_lock2_live = 1'b1;
    step(2);
    rd_chk(8'h48, 8'h33);
    check({7'h0, host_inst.both_locked(v)}, 8'h01);
    rd_chk(8'h46, 8'h00);
    host_inst.wr(8'h48, 8'h04);
    rd_chk(8'h46, 8'h01);
    rd_chk(8'h42, 8'h04);
    check({7'h0, top_irq}, 8'h00);
    host_inst.wr(8'h42, 8'h02);
    rd_chk(8'h42, 8'h07);
    check({7'h0, top_irq}, 8'h01);
    host_inst.wr(8'h48, 8'h26);
    rd_chk(8'h48, 8'h15);
    rd_chk(8'h42, 8'h02);
    pll_lock_live = 1'b0;
    step(2);
    rd_chk(8'h48, 8'h16);
    host_inst.wr(8'h48, 8'h06);
    rd_chk(8'h46, 8'h00);
    // measurement and phase adjust leaves
    measure_done_evt = 1'b1;
    step(1);
    measure_done_evt = 1'b0;
    host_inst.wr(8'h4b, 8'h20);
    rd_chk(8'h43, 8'h01);
    rd_chk(8'h42, 8'h43);
    host_inst.wr(8'h4b, 8'h30);
    rd_chk(8'h43, 8'h00);
    pa_done_evt = 1'b1;
    step(1);
    pa_done_evt = 1'b0;
    host_inst.wr(8'h4d, 8'h08);
    rd_chk(8'h43, 8'h02);
    host_inst.wr(8'h4d, 8'h0c);
    rd_chk(8'h43, 8'h00);
    // each output summary in turn
    for (int i = 0; i < 3; i++) begin
      oc_evt_sum = 3'b001 << i;
      rd_chk(8'h45, 8'h01 << i);
      rd_chk(8'h42, 8'h23);
    end
    oc_evt_sum = 3'h0;
    boot_finished = 1'b1;
    rd_chk(8'h43, 8'h80);
    // reset pin pulse mid-run: boot flag drops, straps caught anew
    reset_pin_n = 1'b0;
    straps = '{test: 1'b0, port_sel: 2'b01, boot_image_strap: 2'b10};
    rd_chk(8'h43, 8'h00);
    reset_pin_n = 1'b1;
    step(2);
    rd_chk(8'h40, 8'h46);
    rd_chk(8'h43, 8'h80);
    give_verdict();
  end
endmodule : testbench
